// ===== core/gcbr_defines.vh
// Constants for the gap-count and bus-reset control block
// Behaviour
// - Trigger bit write starts bus reset sequence
// - Trigger write also loads holdoff and gap
// - Sent or received config packets load both
// - Two resets without update force gap 63
// - Register reflects transmitted config from the next cycle
`ifndef GCBR_DEFINES_VH
`define GCBR_DEFINES_VH
`define GCBR_GAP_W         6
`define GCBR_GAP_MAX       6'h3F
`define GCBR_GAP_RESET     6'h3F
`define GCBR_RHB_RESET     1'b0
`define GCBR_RST_CNT_W     2
`define GCBR_RST_LIMIT     2'h2
`define GCBR_RST_ZERO      2'h0
`define GCBR_RST_ONE       2'h1
`define GCBR_BIT_TRIGGER   7
`define GCBR_BIT_RHB       6
`define GCBR_GAP_MSB       5
`define GCBR_SYNC_ZERO     2'h0
`define GCBR_SYNC_ONES     2'h3
`define GCBR_ST_IDLE       2'h0
`define GCBR_ST_ONE        2'h1
`define GCBR_ST_FORCED     2'h2
`define GCBR_ST_SPARE      2'h3
`endif

// ===== core/gcbr_sync.v
// Two-stage reset release synchroniser
`include "gcbr_defines.vh"

module gcbr_sync (
   // Clock and raw reset
   input  wire clock,
   input  wire resetn,
   // Synchronised reset
   output wire resetn_sync
);
   reg [1:0] stage_q;

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         stage_q <= `GCBR_SYNC_ZERO;
      end else begin
         stage_q <= {stage_q[0], 1'b1};
      end
   end

   assign resetn_sync = stage_q[1];
endmodule // gcbr_sync

// ===== core/gcbr_top.v
// Register 1 control: bus reset trigger, root holdoff and gap count
`include "gcbr_defines.vh"

module gcbr_top #(
   parameter GAP_W = `GCBR_GAP_W
) (
   // Clock and reset
   input  wire             clock,
   input  wire             resetn,
   // Register 1 write port from the link layer
   input  wire             reg1_wr,
   input  wire [7:0]       reg1_wdata,
   // Config packet contents, sent or received
   input  wire             cfg_rx_valid,
   input  wire             cfg_tx_valid,
   input  wire             cfg_root_hold_off,
   input  wire [GAP_W-1:0] cfg_gap_count,
   // Bus reset events seen on the cable
   input  wire             bus_reset_seen,
   // Register 1 read view
   output wire [7:0]       reg1_rdata,
   output reg              root_hold_off_flag,
   output reg  [GAP_W-1:0] gap_count,
   // Request to the arbitration logic
   output reg              bus_reset_start
);
   // Reset-count states: bus resets seen since the last gap update
   localparam [1:0] ST_IDLE   = `GCBR_ST_IDLE;
   localparam [1:0] ST_ONE    = `GCBR_ST_ONE;
   localparam [1:0] ST_FORCED = `GCBR_ST_FORCED;
   localparam [1:0] ST_SPARE  = `GCBR_ST_SPARE;

   // Synchronised reset
   wire             rst_n;

   // Request decode
   wire             trig_wr;
   wire             cfg_load;
   wire             upd;
   wire             force_max;
   wire             wr_rhb;
   wire [GAP_W-1:0] wr_gap;

   // One-hot source select
   reg              src_wr;
   reg              src_cfg;
   reg              src_force;

   // Load strobes per field
   wire             load_rhb;
   wire             load_gap;

   // Next values
   reg  [1:0]       state_q;
   reg  [1:0]       state_d;
   reg              rhb_d;
   wire [GAP_W-1:0] gap_d;
   reg              start_d;

   // Register 1 read view, built field by field
   wire             rd_trig;
   wire             rd_rhb;
   wire [GAP_W-1:0] rd_gap;

   genvar           i;

   gcbr_sync u_sync (
      .clock       (clock),
      .resetn      (resetn),
      .resetn_sync (rst_n)
   );

   // Writes without the trigger bit are dropped whole, so a stray write
   // cannot move the holdoff flag or gap count without a bus reset
   assign trig_wr   = reg1_wr & reg1_wdata[`GCBR_BIT_TRIGGER];
   assign wr_rhb    = reg1_wdata[`GCBR_BIT_RHB];
   assign wr_gap    = reg1_wdata[`GCBR_GAP_MSB:0];

   // Sent and received packets load alike
   assign cfg_load  = cfg_rx_valid | cfg_tx_valid;
   assign upd       = trig_wr | cfg_load;

   // An update in the same cycle as a reset wins and restarts the count;
   // a reset seen while already one deep forces the maximum
   assign force_max = bus_reset_seen & ~upd & (state_q != ST_IDLE);

   // Count bus resets with no gap update in between
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (upd) begin
               state_d = ST_IDLE;
            end else if (bus_reset_seen) begin
               state_d = ST_ONE;
            end
         end
         ST_ONE: begin
            if (upd) begin
               state_d = ST_IDLE;
            end else if (bus_reset_seen) begin
               state_d = ST_FORCED;
            end
         end
         ST_FORCED: begin
            if (upd) begin
               state_d = ST_IDLE;
            end else begin
               state_d = ST_FORCED;
            end
         end
         ST_SPARE: begin
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // Priority: trigger write, then config packet, then the forced maximum
   always @* begin
      src_wr    = 1'b0;
      src_cfg   = 1'b0;
      src_force = 1'b0;
      if (trig_wr) begin
         src_wr = 1'b1;
      end else if (cfg_load) begin
         src_cfg = 1'b1;
      end else if (force_max) begin
         src_force = 1'b1;
      end
   end

   // A bus reset never touches the holdoff flag
   assign load_rhb = src_wr | src_cfg;
   assign load_gap = src_wr | src_cfg | src_force;

   always @* begin
      rhb_d = root_hold_off_flag;
      if (src_wr) begin
         rhb_d = wr_rhb;
      end else if (src_cfg) begin
         rhb_d = cfg_root_hold_off;
      end
   end

   // Same selection per bit; the forced maximum is all ones
   generate
      for (i = 0; i < GAP_W; i = i + 1) begin : g_gap_bit
         assign gap_d[i] = src_wr    ? wr_gap[i] :
                           src_cfg   ? cfg_gap_count[i] :
                           src_force ? 1'b1 :
                                       gap_count[i];
      end
   endgenerate

   // Bus reset request lasts exactly one cycle per trigger write
   always @* begin
      start_d = 1'b0;
      if (trig_wr) begin
         start_d = 1'b1;
      end
   end

   // Reset-count state
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Holdoff flag keeps its value unless a write or packet loads it
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         root_hold_off_flag <= `GCBR_RHB_RESET;
      end else if (load_rhb) begin
         root_hold_off_flag <= rhb_d;
      end
   end

   // Gap count is loaded in the cycle after the packet, so a read right
   // after a transmitted packet already shows the new value
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         gap_count <= `GCBR_GAP_RESET;
      end else if (load_gap) begin
         gap_count <= gap_d;
      end
   end

   // Request to the arbitration logic
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bus_reset_start <= 1'b0;
      end else begin
         bus_reset_start <= start_d;
      end
   end

   // Trigger bit reads back as zero; it is self clearing
   assign rd_trig    = 1'b0;
   assign rd_rhb     = root_hold_off_flag;
   assign rd_gap     = gap_count;
   assign reg1_rdata = {rd_trig, rd_rhb, rd_gap};
endmodule // gcbr_top

// ===== testbench/gcbr_properties.sv
// Gap-count block checker
module gcbr_props (
   input wire logic       clock, resetn, reg1_wr, cfg_rx_valid, cfg_tx_valid, cfg_root_hold_off, bus_reset_seen,
   input wire logic       root_hold_off_flag, bus_reset_start,
   input wire logic [7:0] reg1_wdata, reg1_rdata,
   input wire logic [5:0] cfg_gap_count, gap_count);
   timeunit 1ns;
   timeprecision 1ns;
   wire t = reg1_wr & reg1_wdata[7];
   wire u = t | cfg_rx_valid | cfg_tx_valid;
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   a_trig_load: assert property (t |=> reg1_rdata[6:0] == $past(reg1_wdata[6:0])) else $error("trig");
   a_cfg_load: assert property (u && !t |=> reg1_rdata[6:0] == $past({cfg_root_hold_off, cfg_gap_count})) else $error("cfg");
   a_force_max: assert property (bus_reset_seen && !u ##1 !u ##1 bus_reset_seen && !u |=> gap_count == 6'h3F) else $error("force");
   a_start_pulse: assert property (t |=> bus_reset_start) else $error("start missing");
   a_no_start: assert property (!t |=> !bus_reset_start) else $error("start without trigger");
   a_idle_hold: assert property (!u && !bus_reset_seen |=> $stable(reg1_rdata)) else $error("register moved");
endmodule // gcbr_props
bind gcbr_top gcbr_props gcbr_props_inst (.*);

// ===== testbench/gcbr_peer.sv
// Cable peer: bus resets and config packets
module gcbr_peer (
   input wire logic clock,
   output logic bus_reset_seen = 0, cfg_rx_valid = 0, cfg_tx_valid = 0,
   output logic [6:0] c = 0);
   timeunit 1ns;
   timeprecision 1ns;
   task pulse(input [2:0] k, input [6:0] v);
      {bus_reset_seen, cfg_rx_valid, cfg_tx_valid} <= k;
      c <= v;
      @(posedge clock);
      {bus_reset_seen, cfg_rx_valid, cfg_tx_valid} <= 0;
      c <= ~v;
   endtask
endmodule // gcbr_peer

// ===== testbench/tb.sv
// Gap-count block bench
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 0, resetn = 0, reg1_wr = 0, bus_reset_seen, cfg_rx_valid, cfg_tx_valid, s;
   logic [7:0] reg1_wdata = 0, reg1_rdata;
   logic [6:0] c, m = 7'h3F;
   logic [5:0] g;
   logic f;
   logic [8:0] q[$], e;
   int bad_count = 0, n_compared = 0, n = 0;
   gcbr_top gcbr_top_inst (.*, .cfg_root_hold_off(c[6]), .cfg_gap_count(c[5:0]), .root_hold_off_flag(f),
      .gap_count(g), .bus_reset_start(s));
   gcbr_peer gcbr_peer_inst (.*);
   initial forever #50 clock = ~clock;
   task chk(input [8:0] v, e);
      n_compared++;
      bad_count += (v !== e);
      if (v !== e) $display("MISMATCH %0t %h %h", $time, v, e);
   endtask
   task final_report(input int x);
      bad_count += x;
      $display("%0d compared, %0d bad", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(negedge clock) if (q.size()) begin
      e = q.pop_front();
      chk({s, reg1_rdata}, e);
      chk({s, 1'b0, f, g}, e);
   end
   task go(input [2:0] k, input [7:0] d);
      if (k) gcbr_peer_inst.pulse(k, d[6:0]);
      else begin
         reg1_wr <= 1;
         reg1_wdata <= d;
         @(posedge clock);
         reg1_wr <= 0;
      end
      if (k < 4 && (k || d[7])) begin
         n = 0;
         m = d[6:0];
      end
      if (k == 4 && ++n > 1) m[5:0] = 6'h3F;
      q.push_back({!k && d[7], 1'b0, m});
      @(posedge clock);
   endtask
   initial begin
      n = $urandom(32'hD6B530EB);
      n = 0;
      repeat (16) @(posedge clock);
      resetn <= 1;
      repeat (3) @(posedge clock);
      repeat (40) go(4 >> $urandom_range(3), $urandom);
      $display("random test done");
      go(1, 8'h4A);
      go(0, 8'hCA);
      go(0, {1'b1, m[6], 6'h3F});
      go(2, 8'h05);
      go(4, 0);
      go(4, 0);
      $display("directed test done");
      final_report(0);
   end
   initial #1ms final_report(1);
endmodule // tb
